// >>> hw/pcb_regs.v
// Purpose: Paged configuration register bank behind the serial configuration port
// Assumes: Serial pins synchronous to core_clk, sclk much slower than core_clk
// Notes: Main digital page settings act only after the apply pulse
//
// How it works
// [RULE_01] Writing one to bit 7 or bit 0 of register 0 resets internally, self-clearing.
// [RULE_02] Link page is a 16-bit select in registers 3 and 4.
// [RULE_03] Analog page is chosen by analog_page_select, 80h picks the master page.
// [RULE_04] Pair-write off clear writes both channels, set writes the channel bit's one.
// [RULE_05] Converter_powerdown_set1 holds channel A nibble high, channel B nibble low.
// [RULE_06] Two power-down sets at 20h/21h and 23h/24h, applied through 55h.
// [RULE_07] Host selects master page, then writes 26h with both top bits set.
// [RULE_08] Reset gives low-pass filter, four-lane format and paired writes.
// [RULE_09] Main page settings act after 01h then 00h written to its address 0.
// [RULE_10] Host programs decimation registers on the main page, then pulses apply.
// [RULE_11] Host writes lane maps 0Ah and lane format 01h on link digital page.
// [RULE_12] Two-lane format writes 02h and sets the serializer ratio on analog page.
// [RULE_13] Link digital register 6 low five bits give frames per multiframe.
// [RULE_14] Chip power-down bit only takes a write once the pin-ignore bit is set.
// [RULE_15] Bit 5 of 26h picks set 1 when zero, set 2 when one.
// [RULE_16] Page-local writes hit the selected page; general registers always reachable.
// [RULE_17] Host writes reserved bits zero and always-one bits one.
`timescale 1ns/100ps
`default_nettype none
`include "pcb_defs.vh"

module pcb_regs (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  input wire ce,
  // Serial configuration port
  input wire spi_sen_b,
  input wire spi_sclk,
  input wire spi_sdi,
  output reg spi_sdo,
  // Page selection, pair-write mode and soft reset pulse
  output wire [15:0] link_page_select,
  output wire [7:0] analog_page_select,
  output wire pair_write_off,
  output reg soft_reset_pulse,
  // Power-down controls
  output wire [3:0] converter_a_powerdown,
  output wire [3:0] converter_b_powerdown,
  output wire chip_powerdown,
  output wire powerdown_pin_ignore,
  // Main digital page, applied values
  output wire [3:0] filter_type_select_a,
  output wire [3:0] filter_type_select_b,
  output wire decimation_ctrl_enable_a,
  output wire decimation_ctrl_enable_b,
  // Link settings
  output wire [2:0] lane_format_select_a,
  output wire [2:0] lane_format_select_b,
  output wire [7:0] lane_map_a,
  output wire [7:0] lane_map_b,
  output wire [4:0] multiframe_frames_a,
  output wire [4:0] multiframe_frames_b,
  output wire [1:0] serializer_pll_ratio
);

  // ==========================================================
  // Page decode helpers
  localparam PG_NONE = 3'd0;
  localparam PG_MASTER = 3'd1;
  localparam PG_MAIN = 3'd2;
  localparam PG_LINKDIG = 3'd3;
  localparam PG_LINKANA = 3'd4;

  function [5:0] slot_of;
    input [2:0] pg;
    input [7:0] a;
    begin
      slot_of = 6'h00;
      case (pg)
        PG_MASTER: begin
          case (a)
            `PCB_A_PD1_CONV: slot_of = 6'h20;
            `PCB_A_PD1_BUF: slot_of = 6'h21;
            `PCB_A_PD2_CONV: slot_of = 6'h22;
            `PCB_A_PD2_BUF: slot_of = 6'h23;
            `PCB_A_PD_CTRL: slot_of = 6'h24;
            `PCB_A_PD_APPLY: slot_of = 6'h25;
            default: slot_of = 6'h00;
          endcase
        end
        PG_LINKANA: begin
          case (a)
            `PCB_A_EMP1: slot_of = 6'h26;
            `PCB_A_EMP0: slot_of = 6'h27;
            `PCB_A_EMP2: slot_of = 6'h28;
            `PCB_A_EMP3: slot_of = 6'h29;
            `PCB_A_PLL: slot_of = 6'h2a;
            `PCB_A_OVR: slot_of = 6'h2b;
            `PCB_A_SWING: slot_of = 6'h2c;
            default: slot_of = 6'h00;
          endcase
        end
        PG_MAIN: begin
          case (a)
            `PCB_A_MAIN_PULSE: slot_of = 6'h2d;
            `PCB_A_FILTER: slot_of = 6'h2e;
            `PCB_A_DEC_EN: slot_of = 6'h2f;
            `PCB_A_NYQ: slot_of = 6'h30;
            `PCB_A_GAIN_EN: slot_of = 6'h31;
            `PCB_A_BUS_ORDER: slot_of = 6'h32;
            `PCB_A_LOWBIT_EN: slot_of = 6'h33;
            `PCB_A_LOWBIT: slot_of = 6'h34;
            `PCB_A_DIG_RESET: slot_of = 6'h35;
            default: slot_of = 6'h00;
          endcase
        end
        PG_LINKDIG: begin
          case (a)
            `PCB_A_LINK_CTRL: slot_of = 6'h36;
            `PCB_A_LINK_FMT: slot_of = 6'h37;
            `PCB_A_LINK_TEST: slot_of = 6'h38;
            `PCB_A_MF_CNT: slot_of = 6'h39;
            `PCB_A_SCRAMBLE: slot_of = 6'h3a;
            `PCB_A_MF_LEN: slot_of = 6'h3b;
            `PCB_A_SUBCLASS: slot_of = 6'h3c;
            `PCB_A_MAP_A: slot_of = 6'h3d;
            `PCB_A_MAP_B: slot_of = 6'h3e;
            default: slot_of = 6'h00;
          endcase
        end
        default: slot_of = 6'h00;
      endcase
    end
  endfunction

  function [7:0] rst_val;
    input [4:0] s;
    begin
      if (s == `PCB_SL_LINK_FMT)
        rst_val = `PCB_LINK_FMT_RST; // RULE_08
      else if (s == `PCB_SL_FILTER)
        rst_val = `PCB_FILTER_RST; // RULE_08
      else
        rst_val = 8'h00;
    end
  endfunction

  // ==========================================================
  // State
  reg [7:0] page_lo;
  reg [7:0] page_hi;
  reg [7:0] analog_sel;
  reg pair_off;
  reg [7:0] shadow [0:63];
  reg [7:0] live [0:63];
  reg pulse_armed;
  reg sclk_q;
  reg [4:0] bit_cnt;
  reg [23:0] frame;
  reg [7:0] out_sh;
  reg exec;
  integer i;

  // ==========================================================
  // Frame decode
  wire sclk_rise = spi_sclk & ~sclk_q;
  wire sclk_fall = ~spi_sclk & sclk_q;
  wire [15:0] hdr = frame[15:0];
  wire hdr_rw = hdr[15];
  wire hdr_link = hdr[14];
  wire hdr_paged = hdr[13];
  wire hdr_ch = hdr[12];
  wire hdr_ahi_ok = (hdr[11:8] == 4'h0);
  wire f_link = frame[`PCB_F_LINK];
  wire f_paged = frame[`PCB_F_PAGED];
  wire f_ch = frame[`PCB_F_CH];
  wire [7:0] f_addr = frame[`PCB_F_A];
  wire [7:0] f_data = frame[`PCB_F_D];
  wire f_ahi_ok = (frame[`PCB_F_AHI] == 4'h0);
  wire [15:0] link_pg = {page_hi, page_lo}; // RULE_02

  reg [2:0] cur_link_pg;
  always @* begin
    case (link_pg)
      `PCB_PG_MAIN: cur_link_pg = PG_MAIN;
      `PCB_PG_LINKDIG: cur_link_pg = PG_LINKDIG;
      `PCB_PG_LINKANA: cur_link_pg = PG_LINKANA;
      default: cur_link_pg = PG_NONE;
    endcase
  end

  wire [2:0] cur_ana_pg = (analog_sel == `PCB_PG_MASTER) ? PG_MASTER : PG_NONE; // RULE_03

  // Write side, frame fully shifted in
  wire [2:0] w_pg = f_link ? cur_link_pg : cur_ana_pg; // RULE_16
  wire [5:0] w_hit = slot_of(w_pg, f_addr);
  wire [4:0] w_slot = w_hit[4:0];
  wire w_ok = exec & ~frame[`PCB_F_RW] & f_ahi_ok;
  wire w_gen = w_ok & ~f_paged;
  wire w_loc = w_ok & f_paged & w_hit[5];
  wire w_shared = (w_slot < `PCB_SL_FIRST_CH);

  // Read side, header shifted in
  wire [2:0] r_pg = hdr_link ? cur_link_pg : cur_ana_pg;
  wire [5:0] r_hit = slot_of(r_pg, hdr[7:0]);
  wire r_chb = pair_off & hdr_ch & (r_hit[4:0] >= `PCB_SL_FIRST_CH);

  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (!hdr_ahi_ok) begin
      rd_byte = 8'h00;
    end else if (!hdr_paged) begin
      case (hdr[7:0])
        `PCB_A_LINK_PG_LO: rd_byte = page_lo;
        `PCB_A_LINK_PG_HI: rd_byte = page_hi;
        `PCB_A_PAIR_WRITE: rd_byte = {7'h00, pair_off};
        `PCB_A_ANALOG_PG: rd_byte = analog_sel;
        default: rd_byte = 8'h00;
      endcase
    end else if (r_hit[5]) begin
      rd_byte = shadow[{r_chb, r_hit[4:0]}];
    end
  end

  // ==========================================================
  // Serial engine
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'd0;
      frame <= 24'h000000;
      out_sh <= 8'h00;
      spi_sdo <= 1'b0;
      exec <= 1'b0;
    end else if (ce) begin
      sclk_q <= spi_sclk;
      exec <= 1'b0;
      if (spi_sen_b) begin
        bit_cnt <= 5'd0;
        spi_sdo <= 1'b0;
      end else if (sclk_rise && bit_cnt < `PCB_FRAME_BITS) begin
        frame <= {frame[22:0], spi_sdi};
        bit_cnt <= bit_cnt + 5'd1;
        if (bit_cnt == `PCB_LAST_BIT)
          exec <= 1'b1;
      end else if (bit_cnt == `PCB_HDR_BITS && !sclk_rise && sclk_q && !sclk_fall) begin
        out_sh <= hdr_rw ? rd_byte : 8'h00;
      end else if (sclk_fall && bit_cnt >= `PCB_HDR_BITS && bit_cnt < `PCB_FRAME_BITS) begin
        spi_sdo <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // General registers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_lo <= 8'h00;
      page_hi <= 8'h00;
      analog_sel <= 8'h00;
      pair_off <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else if (ce) begin
      soft_reset_pulse <= w_gen && f_addr == `PCB_A_SOFT_RESET &&
                          (f_data[`PCB_B_RST_HI] | f_data[`PCB_B_RST_LO]); // RULE_01
      if (soft_reset_pulse) begin
        page_lo <= 8'h00;
        page_hi <= 8'h00;
        analog_sel <= 8'h00;
        pair_off <= 1'b0; // RULE_08
      end else if (w_gen) begin
        case (f_addr)
          `PCB_A_LINK_PG_LO: page_lo <= f_data; // RULE_02
          `PCB_A_LINK_PG_HI: page_hi <= f_data; // RULE_02
          `PCB_A_PAIR_WRITE: pair_off <= f_data[0];
          `PCB_A_ANALOG_PG: analog_sel <= f_data; // RULE_03
          default: pair_off <= pair_off;
        endcase
      end
    end
  end

  // ==========================================================
  // Paged registers, two channel copies
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 64; i = i + 1) begin
        shadow[i] <= rst_val(i[4:0]);
        live[i] <= rst_val(i[4:0]);
      end
      pulse_armed <= 1'b0;
    end else if (ce) begin
      if (soft_reset_pulse) begin
        for (i = 0; i < 64; i = i + 1) begin
          shadow[i] <= rst_val(i[4:0]); // RULE_01
          live[i] <= rst_val(i[4:0]);
        end
        pulse_armed <= 1'b0;
      end else if (w_loc) begin
        for (i = 0; i < 2; i = i + 1) begin
          if (w_shared || !pair_off || f_ch == i[0]) begin // RULE_04
            if (w_slot == `PCB_SL_PDCTRL &&
                !(f_data[`PCB_B_PIN_IGN] | shadow[{i[0], w_slot}][`PCB_B_PIN_IGN]))
              shadow[{i[0], w_slot}] <= {shadow[{i[0], w_slot}][`PCB_B_CHIP_PD],
                                         f_data[6:0]}; // RULE_14
            else
              shadow[{i[0], w_slot}] <= f_data; // RULE_16
          end
        end
        if (w_pg == PG_MAIN && f_addr == `PCB_A_MAIN_PULSE) begin
          if (f_data[`PCB_B_PULSE]) begin
            pulse_armed <= 1'b1;
          end else if (pulse_armed) begin
            pulse_armed <= 1'b0;
            for (i = 0; i < 64; i = i + 1) begin
              if (i[4:0] >= `PCB_SL_FIRST_CH && i[4:0] <= `PCB_SL_MAIN_LAST)
                live[i] <= shadow[i]; // RULE_09
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  wire [7:0] pd_ctrl = shadow[{1'b0, `PCB_SL_PDCTRL}];
  wire set_apply = shadow[{1'b0, `PCB_SL_PDAPPLY}][`PCB_B_SET_APPLY];
  wire [7:0] pd_conv = (set_apply && pd_ctrl[`PCB_B_SET_SEL]) ?
                       shadow[{1'b0, `PCB_SL_PD2}] : shadow[{1'b0, `PCB_SL_PD1}]; // RULE_06 RULE_15
  wire [7:0] filt_a = live[{1'b0, `PCB_SL_FILTER}];
  wire [7:0] filt_b = live[{1'b1, `PCB_SL_FILTER}];

  assign link_page_select = link_pg;
  assign analog_page_select = analog_sel;
  assign pair_write_off = pair_off;
  assign converter_a_powerdown = pd_conv[7:4]; // RULE_05
  assign converter_b_powerdown = pd_conv[3:0]; // RULE_05
  assign chip_powerdown = pd_ctrl[`PCB_B_CHIP_PD];
  assign powerdown_pin_ignore = pd_ctrl[`PCB_B_PIN_IGN];
  assign filter_type_select_a = {filt_a[`PCB_B_FILT_HI], filt_a[2:0]};
  assign filter_type_select_b = {filt_b[`PCB_B_FILT_HI], filt_b[2:0]};
  assign decimation_ctrl_enable_a = live[{1'b0, `PCB_SL_DEC_EN}][`PCB_B_DEC_EN];
  assign decimation_ctrl_enable_b = live[{1'b1, `PCB_SL_DEC_EN}][`PCB_B_DEC_EN];
  assign lane_format_select_a = shadow[{1'b0, `PCB_SL_LINK_FMT}][2:0];
  assign lane_format_select_b = shadow[{1'b1, `PCB_SL_LINK_FMT}][2:0];
  assign lane_map_a = shadow[{1'b0, `PCB_SL_MAP_A}];
  assign lane_map_b = shadow[{1'b1, `PCB_SL_MAP_B}];
  assign multiframe_frames_a = shadow[{1'b0, `PCB_SL_MF_LEN}][4:0]; // RULE_13
  assign multiframe_frames_b = shadow[{1'b1, `PCB_SL_MF_LEN}][4:0]; // RULE_13
  assign serializer_pll_ratio = shadow[{1'b0, `PCB_SL_PLL}][1:0];

endmodule // pcb_regs
`default_nettype wire

// >>> pkg/pcb_defs.vh
// Purpose: Constants for the paged configuration register bank
// Assumes: 24-bit serial frame, 16-bit header then 8 data bits
// Notes: Definitions only
`ifndef PCB_DEFS_VH
`define PCB_DEFS_VH

// ==========================================================
// Serial frame layout
`define PCB_FRAME_BITS 5'd24
`define PCB_HDR_BITS 5'd16
`define PCB_LAST_BIT 5'd23
`define PCB_F_RW 23
`define PCB_F_LINK 22
`define PCB_F_PAGED 21
`define PCB_F_CH 20
`define PCB_F_AHI 19:16
`define PCB_F_A 15:8
`define PCB_F_D 7:0

// ==========================================================
// General register addresses
`define PCB_A_SOFT_RESET 8'h00
`define PCB_A_LINK_PG_LO 8'h03
`define PCB_A_LINK_PG_HI 8'h04
`define PCB_A_PAIR_WRITE 8'h05
`define PCB_A_ANALOG_PG 8'h11

// ==========================================================
// Page codes
`define PCB_PG_MASTER 8'h80
`define PCB_PG_MAIN 16'h6800
`define PCB_PG_LINKDIG 16'h6900
`define PCB_PG_LINKANA 16'h6a00

// ==========================================================
// Page-local addresses, master page
`define PCB_A_PD1_CONV 8'h20
`define PCB_A_PD1_BUF 8'h21
`define PCB_A_PD2_CONV 8'h23
`define PCB_A_PD2_BUF 8'h24
`define PCB_A_PD_CTRL 8'h26
`define PCB_A_PD_APPLY 8'h55
// Main digital page
`define PCB_A_MAIN_PULSE 8'h00
`define PCB_A_FILTER 8'h41
`define PCB_A_DEC_EN 8'h4d
`define PCB_A_NYQ 8'h4e
`define PCB_A_GAIN_EN 8'h52
`define PCB_A_BUS_ORDER 8'h72
`define PCB_A_LOWBIT_EN 8'hab
`define PCB_A_LOWBIT 8'had
`define PCB_A_DIG_RESET 8'hf7
// Link digital page
`define PCB_A_LINK_CTRL 8'h00
`define PCB_A_LINK_FMT 8'h01
`define PCB_A_LINK_TEST 8'h02
`define PCB_A_MF_CNT 8'h03
`define PCB_A_SCRAMBLE 8'h05
`define PCB_A_MF_LEN 8'h06
`define PCB_A_SUBCLASS 8'h07
`define PCB_A_MAP_A 8'h31
`define PCB_A_MAP_B 8'h32
// Link analog page
`define PCB_A_EMP1 8'h12
`define PCB_A_EMP0 8'h13
`define PCB_A_EMP2 8'h14
`define PCB_A_EMP3 8'h15
`define PCB_A_PLL 8'h16
`define PCB_A_OVR 8'h1a
`define PCB_A_SWING 8'h1b

// ==========================================================
// Storage slots; below PCB_SL_FIRST_CH they are shared by both channels
`define PCB_SL_PD1 5'd0
`define PCB_SL_PD2 5'd2
`define PCB_SL_PDCTRL 5'd4
`define PCB_SL_PDAPPLY 5'd5
`define PCB_SL_PLL 5'd10
`define PCB_SL_FIRST_CH 5'd13
`define PCB_SL_MAIN_LAST 5'd21
`define PCB_SL_FILTER 5'd14
`define PCB_SL_DEC_EN 5'd15
`define PCB_SL_LINK_FMT 5'd23
`define PCB_SL_MF_LEN 5'd27
`define PCB_SL_MAP_A 5'd29
`define PCB_SL_MAP_B 5'd30

// ==========================================================
// Field positions and reset values
`define PCB_B_RST_HI 7
`define PCB_B_RST_LO 0
`define PCB_B_CHIP_PD 7
`define PCB_B_PIN_IGN 6
`define PCB_B_SET_SEL 5
`define PCB_B_SET_APPLY 4
`define PCB_B_DEC_EN 3
`define PCB_B_FILT_HI 4
`define PCB_B_PULSE 0
`define PCB_FILTER_RST 8'h00
`define PCB_LINK_FMT_RST 8'h01

`endif

// >>> bench/pcb_regs_properties.sv
// Purpose: Port checker for the paged configuration register bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into pcb_regs
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Checker
module pcb_regs_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Serial port
  input wire logic spi_sen_b,
  // Register outputs
  input wire logic [15:0] link_page_select,
  input wire logic [7:0] analog_page_select,
  input wire logic pair_write_off,
  input wire logic soft_reset_pulse,
  input wire logic [3:0] converter_a_powerdown,
  input wire logic [3:0] converter_b_powerdown,
  input wire logic chip_powerdown,
  input wire logic powerdown_pin_ignore,
  input wire logic [3:0] filter_type_select_a,
  input wire logic [2:0] lane_format_select_a,
  input wire logic [2:0] lane_format_select_b,
  input wire logic [4:0] multiframe_frames_a,
  input wire logic [4:0] multiframe_frames_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_pulse_in_frame;
    !spi_sen_b ##1 !soft_reset_pulse;
  endsequence
  sequence s_idle;
    spi_sen_b [*3];
  endsequence
  AST_RST_PULSE_SHAPE: assert property ($rose(soft_reset_pulse) |-> s_pulse_in_frame)
    else $error("soft reset pulse shape wrong");
  AST_RST_CLEARS: assert property (soft_reset_pulse && ce |=> link_page_select == 16'h0000
    && !pair_write_off && lane_format_select_a == 3'b001 && analog_page_select == 8'h00)
    else $error("soft reset did not restore defaults");
  AST_RESET_DEFAULTS: assert property ($rose(rst_b) |-> lane_format_select_a == 3'b001
    && lane_format_select_b == 3'b001 && !pair_write_off && filter_type_select_a == 4'h0)
    else $error("wrong defaults after reset");
  AST_CHIP_PD_GATED: assert property ($rose(chip_powerdown) |-> powerdown_pin_ignore
    || $past(powerdown_pin_ignore))
    else $error("chip power-down set without pin ignore");
  AST_PAIRED_WRITE: assert property ($changed(multiframe_frames_a) && !pair_write_off
    |-> multiframe_frames_b == multiframe_frames_a)
    else $error("paired write reached one channel only");
  AST_APPLY_IN_FRAME: assert property ($changed(filter_type_select_a) |-> !spi_sen_b)
    else $error("applied filter changed outside a frame");
  AST_PAGE_HOLD: assert property (s_idle |-> $stable(link_page_select) && $stable(analog_page_select))
    else $error("page select changed while idle");
  AST_PD_IN_FRAME: assert property ($changed(converter_a_powerdown)
    || $changed(converter_b_powerdown) |-> !spi_sen_b)
    else $error("power-down changed outside a frame");
endmodule // pcb_regs_checker

bind pcb_regs pcb_regs_checker u_chk (.core_clk, .rst_b, .ce, .spi_sen_b, .link_page_select,
  .analog_page_select, .pair_write_off, .soft_reset_pulse, .converter_a_powerdown,
  .converter_b_powerdown, .chip_powerdown, .powerdown_pin_ignore, .filter_type_select_a,
  .lane_format_select_a, .lane_format_select_b, .multiframe_frames_a, .multiframe_frames_b);
`default_nettype wire

// >>> bench/pcb_host.sv
// Purpose: Host model driving the serial configuration port
// Assumes: Serial clock low for four core_clk cycles, high for three
// Notes: Data line toggles when released
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Host
module pcb_host (
  // Clock
  input wire logic core_clk,
  // Serial port
  output logic spi_sen_b,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sen_b = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end
  // One 24-bit frame, MSB first
  task automatic xfer(input logic [23:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk);
    spi_sen_b <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge core_clk);
      spi_sdi <= frame[i];
      repeat (3) @(posedge core_clk);
      if (i < 8) rd = {rd[6:0], spi_sdo};
      spi_sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    spi_sen_b <= 1'b1;
    spi_sdi <= ~spi_sdi;
    repeat (2) @(posedge core_clk);
  endtask
endmodule // pcb_host
`default_nettype wire

// >>> bench/test_paged_config_register_bank.sv
// Purpose: Self-checking bench for the paged configuration register bank
// Assumes: Host model drives the serial port
// Notes: One task per scenario
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Bench
module test_paged_config_register_bank;
  logic core_clk, rst_b, ce, spi_sen_b, spi_sclk, spi_sdi, spi_sdo;
  logic pair_write_off, soft_reset_pulse, chip_powerdown, powerdown_pin_ignore;
  logic decimation_ctrl_enable_a, decimation_ctrl_enable_b;
  logic [15:0] link_page_select;
  logic [7:0] analog_page_select, lane_map_a, lane_map_b, r;
  logic [3:0] converter_a_powerdown, converter_b_powerdown, filter_type_select_a, filter_type_select_b;
  logic [2:0] lane_format_select_a, lane_format_select_b;
  logic [4:0] multiframe_frames_a, multiframe_frames_b;
  logic [1:0] serializer_pll_ratio;
  int bad_count = 0;
  int checked = 0;
  int pulse_count = 0;

  pcb_regs u_dut (.core_clk, .rst_b, .ce, .spi_sen_b, .spi_sclk, .spi_sdi, .spi_sdo, .link_page_select,
    .analog_page_select, .pair_write_off, .soft_reset_pulse, .converter_a_powerdown, .converter_b_powerdown,
    .chip_powerdown, .powerdown_pin_ignore, .filter_type_select_a, .filter_type_select_b,
    .decimation_ctrl_enable_a, .decimation_ctrl_enable_b, .lane_format_select_a, .lane_format_select_b,
    .lane_map_a, .lane_map_b, .multiframe_frames_a, .multiframe_frames_b, .serializer_pll_ratio);
  pcb_host u_host (.core_clk, .spi_sen_b, .spi_sclk, .spi_sdi, .spi_sdo);

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (soft_reset_pulse === 1'b1) pulse_count <= pulse_count + 1;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Header reserved bits always zero
  task wr(input logic lk, input logic pg, input logic ch, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_host.xfer({1'b0, lk, pg, ch, 4'h0, a, d}, unused);
  endtask
  task rd(input logic lk, input logic pg, input logic ch, input logic [7:0] a);
    u_host.xfer({1'b1, lk, pg, ch, 4'h0, a, 8'h00}, r);
  endtask
  task sel_link(input logic [15:0] p);
    wr(1'b0, 1'b0, 1'b0, 8'h04, p[15:8]);
    wr(1'b0, 1'b0, 1'b0, 8'h03, p[7:0]);
  endtask

  // ==========================================
  // Scenarios
  task t_reset;
    check("fmt a", lane_format_select_a, 3'b001);
    check("fmt b", lane_format_select_b, 3'b001);
    check("pair off", pair_write_off, 1'b0);
    check("filter a", filter_type_select_a, 4'h0);
    rd(1'b0, 1'b0, 1'b0, 8'h03);
    check("page lo read", r, 8'h00);
    rd(1'b0, 1'b0, 1'b0, 8'h00);
    check("reset read", r, 8'h00);
  endtask
  task t_pages;
    sel_link(16'h6800);
    check("link page", link_page_select, 16'h6800);
    rd(1'b0, 1'b0, 1'b0, 8'h04);
    check("page hi read", r, 8'h68);
    wr(1'b0, 1'b0, 1'b0, 8'h11, 8'h80);
    check("analog page", analog_page_select, 8'h80);
  endtask
  task t_power;
    wr(1'b0, 1'b1, 1'b0, 8'h20, 8'h0f);
    check("pd a", converter_a_powerdown, 4'h0);
    check("pd b", converter_b_powerdown, 4'hf);
    wr(1'b0, 1'b1, 1'b0, 8'h23, 8'hf0);
    wr(1'b0, 1'b1, 1'b0, 8'h26, 8'h20);
    wr(1'b0, 1'b1, 1'b0, 8'h55, 8'h10);
    check("pd a set2", converter_a_powerdown, 4'hf);
    check("pd b set2", converter_b_powerdown, 4'h0);
    wr(1'b0, 1'b1, 1'b0, 8'h26, 8'h80);
    check("chip pd early", chip_powerdown, 1'b0);
    wr(1'b0, 1'b1, 1'b0, 8'h26, 8'hc0);
    check("chip pd", chip_powerdown, 1'b1);
    check("pin ignore", powerdown_pin_ignore, 1'b1);
    check("pd a set1", converter_a_powerdown, 4'h0);
  endtask
  task t_apply;
    sel_link(16'h6800);
    wr(1'b1, 1'b1, 1'b0, 8'h41, 8'h16);
    wr(1'b1, 1'b1, 1'b0, 8'h4d, 8'h08);
    wr(1'b1, 1'b1, 1'b0, 8'h72, 8'h08);
    wr(1'b1, 1'b1, 1'b0, 8'h52, 8'h80);
    check("filter early", filter_type_select_a, 4'h0);
    wr(1'b1, 1'b1, 1'b0, 8'h00, 8'h01);
    check("filter armed", filter_type_select_a, 4'h0);
    wr(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
    check("filter a", filter_type_select_a, 4'he);
    check("filter b", filter_type_select_b, 4'he);
    check("dec a", decimation_ctrl_enable_a, 1'b1);
    check("dec b", decimation_ctrl_enable_b, 1'b1);
  endtask
  task t_link;
    sel_link(16'h6900);
    wr(1'b1, 1'b1, 1'b0, 8'h31, 8'h0a);
    wr(1'b1, 1'b1, 1'b0, 8'h32, 8'h0a);
    wr(1'b1, 1'b1, 1'b0, 8'h01, 8'h01);
    check("map a", lane_map_a, 8'h0a);
    check("map b", lane_map_b, 8'h0a);
    check("fmt a", lane_format_select_a, 3'b001);
    wr(1'b1, 1'b1, 1'b0, 8'h01, 8'h02);
    check("fmt b", lane_format_select_b, 3'b010);
    wr(1'b1, 1'b1, 1'b0, 8'h06, 8'h3f);
    check("frames a", multiframe_frames_a, 5'h1f);
    sel_link(16'h6a00);
    wr(1'b1, 1'b1, 1'b0, 8'h16, 8'h02);
    check("pll", serializer_pll_ratio, 2'b10);
    wr(1'b1, 1'b1, 1'b0, 8'h06, 8'h03);
    check("frames b", multiframe_frames_b, 5'h1f);
  endtask
  task t_pair;
    wr(1'b0, 1'b0, 1'b0, 8'h05, 8'h01);
    check("pair off", pair_write_off, 1'b1);
    sel_link(16'h6900);
    wr(1'b1, 1'b1, 1'b1, 8'h06, 8'h05);
    check("frames b", multiframe_frames_b, 5'h05);
    check("frames a", multiframe_frames_a, 5'h1f);
    wr(1'b1, 1'b1, 1'b0, 8'h06, 8'h07);
    check("frames a", multiframe_frames_a, 5'h07);
    check("frames b", multiframe_frames_b, 5'h05);
    rd(1'b1, 1'b1, 1'b1, 8'h06);
    check("frames b read", r, 8'h05);
  endtask
  task t_soft;
    logic [7:0] codes [2];
    int n;
    codes = '{8'h80, 8'h01};
    foreach (codes[i]) begin
      wr(1'b0, 1'b0, 1'b0, 8'h05, 8'h01);
      n = pulse_count;
      wr(1'b0, 1'b0, 1'b0, 8'h00, codes[i]);
      check("pulses", pulse_count - n, 16'h0001);
      check("pair off", pair_write_off, 1'b0);
      check("fmt a", lane_format_select_a, 3'b001);
      check("link page", link_page_select, 16'h0000);
      check("frames a", multiframe_frames_a, 5'h00);
    end
  endtask
  task t_hold;
    sel_link(16'h6900);
    @(posedge core_clk) ce <= 1'b0;
    wr(1'b1, 1'b1, 1'b0, 8'h06, 8'h0c);
    @(posedge core_clk) ce <= 1'b1;
    check("frames frozen", multiframe_frames_a, 5'h00);
    wr(1'b1, 1'b1, 1'b0, 8'h06, 8'h0c);
    check("frames a", multiframe_frames_a, 5'h0c);
    check("frames b", multiframe_frames_b, 5'h0c);
    @(posedge core_clk) rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("frames rst", multiframe_frames_a, 5'h00);
    check("page rst", link_page_select, 16'h0000);
    check("fmt b rst", lane_format_select_b, 3'b001);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset;
    t_pages;
    t_power;
    t_apply;
    t_link;
    t_pair;
    t_soft;
    t_hold;
    results;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    $display("[FAIL] run expected done seen hang");
    results;
  end
endmodule // test_paged_config_register_bank
`default_nettype wire
